// *** design/tmc_pkg.sv ***
/*
  shared constants, types and register map of the up-mode timer with
  compare channels.
  assumes a 16-bit register port with byte addresses, one word per register.
*/
package tmc_pkg;

  // register port
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 16;

  // register offsets
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] COUNT_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR   = 8'h0C;
  localparam logic [7:0] CH_VAL_BASE = 8'h10;
  localparam logic [7:0] CH_MOD_BASE = 8'h20;
  localparam logic [7:0] CH_STRIDE   = 8'h04;

  // control field layout, low bits first: mode, divider, source, clear
  localparam int unsigned CTRL_W       = 6;
  localparam int unsigned CTRL_CLR_BIT = 6;
  localparam int unsigned STAT_WRAP    = 0;
  localparam int unsigned STAT_CH0     = 1;
  localparam int unsigned CHM_CAP_BIT  = 0;

  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] VALUE_RST = 16'h0000;

  // counting modes, gray along stop -> up -> continuous
  typedef enum logic [1:0] {
    TMC_STOP = 2'h0,
    TMC_UP   = 2'h1,
    TMC_CONT = 2'h3
  } tmc_mode_e;

  // clock sources
  localparam logic [1:0] SRC_INV_EXT = 2'h0;
  localparam logic [1:0] SRC_SUBSYS  = 2'h1;
  localparam logic [1:0] SRC_AUX     = 2'h2;
  localparam logic [1:0] SRC_EXT_TMR = 2'h3;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] input_divider_code;
    tmc_mode_e  mode;
  } tmc_ctrl_s;

  localparam tmc_ctrl_s CTRL_RST = '{src: 2'h0, input_divider_code: 2'h0,
                                     mode: TMC_STOP};

endpackage

// *** design/tmc_divider.sv ***
/*
  input divider: passes one of every 1, 2, 4 or 8 source edges as a tick.
  assumes edges are one-cycle pulses on the same clock as the divider.
*/
`timescale 1ns/1ns
module tmc_divider
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // control
  input  wire logic       clear,
  input  wire logic [1:0] input_divider_code,
  // edges in, ticks out
  input  wire logic       src_edge,
  output logic            tick
);

  logic [2:0] div_cnt_r;
  logic [2:0] div_last;

  // last phase index: 0, 1, 3 or 7
  assign div_last = 3'((4'h1 << input_divider_code) - 4'h1);
  assign tick     = src_edge && (div_cnt_r == div_last);

  // a clear restarts the phase, so the first tick also waits the full count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 3'h0;
    end else if (clear || tick) begin
      div_cnt_r <= 3'h0;
    end else if (src_edge) begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

endmodule

// *** design/tmc_channel.sv ***
/*
  one capture/compare channel: holds its value and mode, flags a match
  or a capture.
  assumes tick, count and count_nxt come from the counter on this clock.
*/
`timescale 1ns/1ns
module tmc_channel
  import tmc_pkg::*;
#(
  parameter int unsigned W = 16
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // register writes
  input  wire logic         wr_value,
  input  wire logic         wr_mode,
  input  wire logic [W-1:0] wdata,
  input  wire logic         wdata_cap,
  // counter view
  input  wire logic         tick,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] count_nxt,
  input  wire logic         cap_edge,
  // state out
  output logic [W-1:0]      value,
  output logic              capture_mode,
  output logic              evt
);

  logic [W-1:0] cmp_target;

  // a value written in the tick cycle is already the one compared,
  // so a bump by one can never slip past the next increment
  assign cmp_target = wr_value ? wdata : value;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value <= W'(VALUE_RST);
    end else if (wr_value) begin
      value <= wdata;
    end else if (capture_mode && cap_edge) begin
      value <= count;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capture_mode <= 1'b0;
    end else if (wr_mode) begin
      capture_mode <= wdata_cap;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt <= 1'b0;
    end else begin
      evt <= (tick && !capture_mode && count_nxt == cmp_target) ||
             (capture_mode && cap_edge);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_cmp_event;
    tick && !capture_mode && !wr_value && count_nxt == value |=> evt;
  endproperty
  a_cmp_event: assert property (p_cmp_event)
    else $error("compare match gave no channel event");

  sequence s_bump;
    wr_value && wdata == W'(value + W'(1)) && !capture_mode;
  endsequence
  property p_bump;
    s_bump ##0 (tick && count_nxt == wdata) |=> evt;
  endproperty
  a_bump: assert property (p_bump)
    else $error("raised compare value lost its event");

  property p_capture_quiet;
    capture_mode && !cap_edge |=> !evt;
  endproperty
  a_capture_quiet: assert property (p_capture_quiet)
    else $error("channel in capture mode raised a compare event");

endmodule

// *** design/tmc_timer.sv ***
/*
  up-mode timer with compare channels: source select, input divider,
  running count, period wrap, sticky flags, mask and interrupt.
  assumes clock pins are asynchronous and much slower than clock, and a
  register master that never holds two strobes at once.
*/
// What this block does
// - a compare-mode channel flags when the count becomes its compare value
// - a compare value raised by one still matches on the next increment
// - count advances on pin edges of one of four selectable sources: falling for the inverted one, rising for the rest
// - reset or a write of the clear bit zeroes the running count
// - every increment, the first after a clear too, obeys the divider
// - in up mode the wrap flag sets only on period value to zero
// - restarting after a clear at the period value sets no wrap flag
// - software switches each channel between capture and compare mode
`timescale 1ns/1ns
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int unsigned W  = 16,
  parameter int unsigned CH = 3
)(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  // clock source pins
  input  wire logic              inverted_external_clock,
  input  wire logic              subsystem_clock,
  input  wire logic              aux_clock,
  input  wire logic              external_timer_clock,
  // capture inputs
  input  wire logic [CH-1:0]     cap_in,
  // interrupt
  output logic                   irq
);

  localparam int unsigned SW = CH + 1;
  localparam int unsigned NP = 4 + CH;

  logic            rst_s1_r;
  logic            rst_n;
  logic [NP-1:0]   pin_s1_r;
  logic [NP-1:0]   pin_s2_r;
  logic [NP-1:0]   pin_s3_r;
  logic [NP-1:0]   pin_rise;
  logic            src_edge;
  logic            run;
  logic            tick;
  logic            tick_ok;
  tmc_ctrl_s       ctrl_r;
  logic            clear_req;
  logic [W-1:0]    running_count_r;
  logic [W-1:0]    count_nxt;
  logic            wrap_c;
  logic            wrap_evt;
  logic [W-1:0]    period_compare_value;
  logic [W-1:0]    ch_value [CH];
  logic [CH-1:0]   ch_cap;
  logic [CH-1:0]   ch_evt;
  logic [CH-1:0]   ch_wr_val;
  logic [CH-1:0]   ch_wr_mod;
  logic [SW-1:0]   status_r;
  logic [SW-1:0]   status_nxt;
  logic [SW-1:0]   mask_r;
  logic [SW-1:0]   mask_nxt;
  logic [SW-1:0]   events;
  logic            rd_status;
  logic [DATA_W-1:0] rdata_nxt;

  // reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // pin synchronisers; edges are taken only from the second stage on
  // the inverted pin idles low, so its stages reset high: no false edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= NP'(1);
      pin_s2_r <= NP'(1);
      pin_s3_r <= NP'(1);
    end else begin
      pin_s1_r <= {cap_in, external_timer_clock, aux_clock,
                   subsystem_clock, ~inverted_external_clock};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;

  // source select; the inverted input counts on its falling pin edge
  always_comb begin
    unique case (ctrl_r.src)
      SRC_INV_EXT: src_edge = pin_rise[0];
      SRC_SUBSYS:  src_edge = pin_rise[1];
      SRC_AUX:     src_edge = pin_rise[2];
      SRC_EXT_TMR: src_edge = pin_rise[3];
    endcase
  end

  // control register
  assign clear_req = wr && addr == CTRL_ADDR && wdata[CTRL_CLR_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr && addr == CTRL_ADDR) begin
      ctrl_r <= tmc_ctrl_s'(wdata[CTRL_W-1:0]);
    end
  end

  assign run = (ctrl_r.mode == TMC_UP) || (ctrl_r.mode == TMC_CONT);

  // divider only sees edges while running, so stopping keeps the phase
  tmc_divider u_div (
    .clock              (clock),
    .rst_n              (rst_n),
    .clear              (clear_req),
    .input_divider_code (ctrl_r.input_divider_code),
    .src_edge           (src_edge && run),
    .tick               (tick)
  );

  assign tick_ok = tick && run && !clear_req;

  // next count and wrap condition per mode
  always_comb begin
    count_nxt = running_count_r;
    wrap_c    = 1'b0;
    unique case (ctrl_r.mode)
      TMC_STOP: begin
        count_nxt = running_count_r;
      end
      TMC_UP: begin
        wrap_c    = running_count_r == period_compare_value;
        count_nxt = wrap_c ? '0 : W'(running_count_r + W'(1));
      end
      TMC_CONT: begin
        wrap_c    = &running_count_r;
        count_nxt = W'(running_count_r + W'(1));
      end
      default: begin
        count_nxt = running_count_r;
      end
    endcase
  end

  // wrap comes only from counting; a clear never produces it
  assign wrap_evt = tick_ok && wrap_c;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_count_r <= W'(COUNT_RST);
    end else if (clear_req) begin
      running_count_r <= W'(COUNT_RST);
    end else if (tick_ok) begin
      running_count_r <= count_nxt;
    end
  end

  // channels; channel zero sets the up-mode period
  genvar gi;
  generate
    for (gi = 0; gi < CH; gi++) begin : g_ch
      assign ch_wr_val[gi] = wr &&
        addr == 8'(CH_VAL_BASE + 8'(gi) * CH_STRIDE);
      assign ch_wr_mod[gi] = wr &&
        addr == 8'(CH_MOD_BASE + 8'(gi) * CH_STRIDE);
      tmc_channel #(.W(W)) u_ch (
        .clock        (clock),
        .rst_n        (rst_n),
        .wr_value     (ch_wr_val[gi]),
        .wr_mode      (ch_wr_mod[gi]),
        .wdata        (wdata[W-1:0]),
        .wdata_cap    (wdata[CHM_CAP_BIT]),
        .tick         (tick_ok),
        .count        (running_count_r),
        .count_nxt    (count_nxt),
        .cap_edge     (pin_rise[4+gi]),
        .value        (ch_value[gi]),
        .capture_mode (ch_cap[gi]),
        .evt          (ch_evt[gi])
      );
    end
  endgenerate

  assign period_compare_value = ch_value[0];

  // sticky flags: a read clears, an event in the same cycle still sets
  assign events    = {ch_evt, wrap_evt};
  assign rd_status = rd && addr == STATUS_ADDR;
  assign status_nxt = (rd_status ? '0 : status_r) | events;
  assign mask_nxt  = (wr && addr == MASK_ADDR) ? wdata[SW-1:0] : mask_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // irq built from next values so it tracks the flags with no lag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & mask_nxt);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (addr)
      CTRL_ADDR:   rdata_nxt = DATA_W'(ctrl_r);
      COUNT_ADDR:  rdata_nxt = DATA_W'(running_count_r);
      STATUS_ADDR: rdata_nxt = DATA_W'(status_r);
      MASK_ADDR:   rdata_nxt = DATA_W'(mask_r);
      default: begin
        for (int i = 0; i < CH; i++) begin
          if (addr == 8'(CH_VAL_BASE + 8'(i) * CH_STRIDE)) begin
            rdata_nxt = DATA_W'(ch_value[i]);
          end
          if (addr == 8'(CH_MOD_BASE + 8'(i) * CH_STRIDE)) begin
            rdata_nxt = DATA_W'(ch_cap[i]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= '0;
    end
  end

  // helper: source edges seen since the last clear or tick
  logic [3:0] hlp_edges_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hlp_edges_r <= 4'h0;
    end else if (clear_req || tick) begin
      hlp_edges_r <= 4'h0;
    end else if (src_edge && run) begin
      hlp_edges_r <= hlp_edges_r + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_clear_zero;
    clear_req |=> running_count_r == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("count not zero after clear");

  property p_advance;
    tick_ok && ctrl_r.mode == TMC_CONT && !(wr && addr == CTRL_ADDR)
      |=> running_count_r == W'($past(running_count_r) + W'(1));
  endproperty
  a_advance: assert property (p_advance)
    else $error("count did not advance on tick");

  property p_divided;
    tick |-> 4'(hlp_edges_r + 4'h1) ==
             (4'h1 << ctrl_r.input_divider_code);
  endproperty
  a_divided: assert property (p_divided)
    else $error("tick after wrong number of source edges");

  property p_wrap_up;
    tick_ok && ctrl_r.mode == TMC_UP &&
      running_count_r == period_compare_value
      |=> running_count_r == '0 && status_r[STAT_WRAP];
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("up mode did not wrap at period value");

  property p_wrap_only;
    wrap_evt && ctrl_r.mode == TMC_UP |->
      running_count_r == period_compare_value;
  endproperty
  a_wrap_only: assert property (p_wrap_only)
    else $error("wrap flagged away from period value");

  sequence s_cleared;
    clear_req ##1 (running_count_r == '0 && period_compare_value != '0);
  endsequence
  property p_no_restart_wrap;
    s_cleared |-> !wrap_evt;
  endproperty
  a_no_restart_wrap: assert property (p_no_restart_wrap)
    else $error("wrap flagged right after clear");

  property p_flag_sticks;
    status_r[STAT_CH0] && !rd_status |=> status_r[STAT_CH0];
  endproperty
  a_flag_sticks: assert property (p_flag_sticks)
    else $error("channel flag dropped without a status read");

  property p_irq;
    irq == |(status_r & mask_r);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow masked flags");

endmodule

// *** test/tmc_src_model.sv ***
/*
  far-side model of the four timer clock source pins.
  assumes one request at a time; each request makes one pin pulse.
*/
`timescale 1ns/1ns
module tmc_src_model (
  // clock
  input  wire logic       clock,
  // request
  input  wire logic       go,
  input  wire logic [1:0] sel,
  // pins and state
  output logic [3:0]      pins,
  output logic            busy
);
  logic [3:0] cnt_r = 4'h0;
  logic [1:0] sel_r = 2'h0;
  logic       busy_r = 1'b0;

  always_ff @(posedge clock) begin
    if (go && !busy_r) begin
      busy_r <= 1'b1;
      sel_r  <= sel;
      cnt_r  <= 4'hF;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0) begin
        busy_r <= 1'b0;
      end
    end
  end

  // pins rest low: a source clock stands still between requests
  // one rising then one falling edge per request, 8 cycles each
  assign pins = (busy_r && cnt_r[3]) ? (4'h1 << sel_r) : 4'h0;
  assign busy = busy_r;
endmodule

// *** test/up_mode_timer_compare_tb.sv ***
/*
  self-checking bench of the up-mode timer with compare channels.
  assumes the register port answers in the cycle after a read strobe.
*/
`timescale 1ns/1ns
module up_mode_timer_compare_tb;
  import tmc_pkg::*;
  typedef struct {
    logic [1:0] src;
    logic [1:0] div;
    int         n;
    logic [15:0] exp;
  } tmc_row_s;

  logic              clock;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        pin;
  logic [2:0]        cap_in;
  logic              irq;
  logic              go;
  logic [1:0]        sel;
  logic              busy;
  logic [15:0]       v;
  int                n_mismatch;
  int                checks;
  int                i;
  tmc_row_s          rows [7];
  logic [7:0]        rst_addr [9];

  tmc_timer i_dut (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .inverted_external_clock(pin[0]),
    .subsystem_clock(pin[1]), .aux_clock(pin[2]),
    .external_timer_clock(pin[3]), .cap_in(cap_in), .irq(irq));
  tmc_src_model i_src (
    .clock(clock), .go(go), .sel(sel), .pins(pin), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [15:0] cw(logic c, logic [1:0] s,
                                     logic [1:0] d, logic [1:0] m);
    return {9'h000, c, s, d, m};
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk16(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkr(input string n, input logic [7:0] a,
                      input logic [15:0] e);
    logic [15:0] g;
    rreg(a, g);
    chk16(n, e, g);
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // waits are bounded: a stuck model shows as a wrong count later
  task automatic pulse(input logic [1:0] s, input int n);
    int k;
    int t;
    for (k = 0; k < n; k++) begin
      @(posedge clock);
      sel <= s;
      go  <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      for (t = 0; t < 40; t++) begin
        @(posedge clock);
        if (busy === 1'b0) break;
      end
    end
    repeat (8) @(posedge clock);
  endtask

  // one source pulse with a register write landing on the tick edge
  task automatic pulse_wr(input logic [1:0] s, input logic [7:0] a,
                          input logic [15:0] d);
    @(posedge clock);
    sel <= s;
    go  <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    repeat (24) @(posedge clock);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    test_done();
  end

  initial begin
    rstn = 1'b0; addr = 8'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    cap_in = 3'b000; go = 1'b0; sel = 2'h0;
    n_mismatch = 0;
    checks = 0;
    rows = '{'{2'h0, 2'h0, 3, 16'h0003}, '{2'h1, 2'h1, 1, 16'h0000},
             '{2'h1, 2'h1, 3, 16'h0001}, '{2'h2, 2'h2, 7, 16'h0001},
             '{2'h3, 2'h3, 7, 16'h0000}, '{2'h3, 2'h3, 8, 16'h0001},
             '{2'h1, 2'h2, 9, 16'h0002}};
    rst_addr = '{CTRL_ADDR, COUNT_ADDR, STATUS_ADDR, MASK_ADDR, 8'h10,
                 8'h14, 8'h20, 8'h28, 8'h3C};
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    for (i = 0; i < 9; i++) begin
      chkr("reset value", rst_addr[i], 16'h0000);
    end
    chk1("irq", 1'b0, irq);
    // source, divider and clear table; period kept far away
    wreg(CH_VAL_BASE, 16'hFFFF);
    for (i = 0; i < 7; i++) begin
      wreg(CTRL_ADDR, cw(1'b1, rows[i].src, rows[i].div, TMC_UP));
      pulse(rows[i].src, rows[i].n);
      chkr("count", COUNT_ADDR, rows[i].exp);
    end
    // compare flags and wrap at the period value
    wreg(MASK_ADDR, 16'h000F);
    wreg(CH_VAL_BASE, 16'h0003);
    wreg(CH_VAL_BASE + CH_STRIDE, 16'h0002);
    wreg(CH_VAL_BASE + 8'h08, 16'hFFF0);
    wreg(CTRL_ADDR, cw(1'b1, 2'h1, 2'h0, TMC_UP));
    rreg(STATUS_ADDR, v);
    pulse(2'h1, 2);
    chk1("irq", 1'b1, irq);
    chkr("status", STATUS_ADDR, 16'h0004);
    @(posedge clock);
    chk1("irq", 1'b0, irq);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0002);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0001);
    chkr("count", COUNT_ADDR, 16'h0000);
    // compare value raised by one just after its match
    wreg(CH_VAL_BASE + CH_STRIDE, 16'h0001);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0004);
    wreg(CH_VAL_BASE + CH_STRIDE, 16'h0002);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0004);
    // raise by one in the very cycle of the increment, then stop there
    pulse_wr(2'h1, CH_VAL_BASE + CH_STRIDE, 16'h0003);
    chkr("status", STATUS_ADDR, 16'h0006);
    // stop at the period value, clear, restart in up mode
    wreg(CTRL_ADDR, cw(1'b0, 2'h1, 2'h0, TMC_STOP));
    wreg(CTRL_ADDR, cw(1'b1, 2'h1, 2'h0, TMC_UP));
    rreg(STATUS_ADDR, v);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0000);
    chkr("count", COUNT_ADDR, 16'h0001);
    // capture mode while the compare value is updated
    wreg(CH_MOD_BASE + 8'h08, 16'h0001);
    @(posedge clock);
    cap_in <= 3'b100;
    @(posedge clock);
    cap_in <= 3'b000;
    repeat (6) @(posedge clock);
    chkr("captured", CH_VAL_BASE + 8'h08, 16'h0001);
    chkr("status", STATUS_ADDR, 16'h0008);
    wreg(CH_VAL_BASE + 8'h08, 16'h0002);
    wreg(CH_MOD_BASE + 8'h08, 16'h0000);
    pulse(2'h1, 1);
    chkr("status", STATUS_ADDR, 16'h0008);
    // masked event holds irq low until the mask opens
    wreg(MASK_ADDR, 16'h0000);
    pulse(2'h1, 1);
    chk1("irq", 1'b0, irq);
    wreg(MASK_ADDR, 16'h000F);
    @(posedge clock);
    chk1("irq", 1'b1, irq);
    chkr("status", STATUS_ADDR, 16'h0006);
    // continuous mode runs on past the period value
    wreg(CTRL_ADDR, cw(1'b0, 2'h1, 2'h0, TMC_CONT));
    pulse(2'h1, 2);
    chkr("count", COUNT_ADDR, 16'h0005);
    // second reset in mid-run
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    chkr("count", COUNT_ADDR, 16'h0000);
    chkr("ctrl", CTRL_ADDR, 16'h0000);
    test_done();
  end
endmodule
